//--- src/rsc_sequence.sv
// Frame sequencing, preload gating and walk strobes for the resampler
`timescale 1ns/1ps
module rsc_sequence
  import rsc_pkg::*;
#(
  parameter int CNT_W = rsc_pkg::RSC_CNT_W
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     arst_n,
  // Control pins
  input  wire logic                     restart,
  input  wire logic                     run_on,
  input  wire logic                     stall_n,
  input  wire logic                     param_select_n,
  input  wire logic                     param_write_n,
  // Preload side
  input  wire rsc_pkg::rsc_geom_t       preload_geom,
  input  wire logic [RSC_DELAY_W-1:0]   sum_clear_delay,
  input  wire logic [RSC_DELAY_W-1:0]   target_store_delay,
  // Target enable pin
  input  wire logic                     target_port_enable_n,
  // Outputs
  output logic                          param_load_strobe_n,
  output logic                          source_valid,
  output logic                          sum_clear_n,
  output logic                          target_store_n,
  output logic                          target_store_oe,
  output rsc_pkg::rsc_geom_t            working_geom
);
  import rsc_pkg::*;

  // Counters and geometry share one width; a mismatch would truncate
  if (CNT_W != RSC_CNT_W) begin : g_bad_width
    $error("CNT_W must match package width");
  end

  typedef struct packed {
    rsc_ctrl_t                s1;
    rsc_ctrl_t                s2;
    logic [1:0]               wr_s;
    logic [1:0]               oe_s;
    rsc_state_t               state;
    logic [3:0]               lat;
    logic [CNT_W-1:0]         walk;
    logic [CNT_W-1:0]         pix;
    logic [CNT_W-1:0]         line;
    rsc_geom_t                work;
    logic [RSC_DELAY_MAX:0]   clr_pipe;
    logic [RSC_DELAY_MAX:0]   st_pipe;
    logic                     load_n;
    logic                     valid;
    logic                     clr_n;
    logic                     st_n;
    logic                     st_oe;
  } rsc_regs_t;

  rsc_regs_t r;
  rsc_regs_t next_r;

  logic walk_first;
  logic walk_last;
  logic line_last;
  logic frame_last;
  logic line_first_cyc;
  logic advance;

  always_comb begin
    next_r = r;

    // Two-flop synchronisers on every control and enable pin, not on the preload side
    // Pins are asynchronous to clk, so no logic reads the first flop
    next_r.s1   = '{restart, run_on, stall_n, param_select_n};
    next_r.s2   = r.s1;
    next_r.wr_s = {r.wr_s[0], param_write_n};
    next_r.oe_s = {r.oe_s[0], target_port_enable_n};

    // Walk position decode
    // Compared against the working set, never the preload set
    walk_first     = (r.walk == '0);
    walk_last      = (r.walk == r.work.walk_len - CNT_W'(1));
    line_last      = walk_last && (r.pix == r.work.line_len - CNT_W'(1));
    frame_last     = line_last && (r.line == r.work.line_cnt - CNT_W'(1));
    line_first_cyc = walk_first && (r.pix == '0)
                     && (r.line == r.work.line_cnt - CNT_W'(1));
    advance        = 1'b0;

    next_r.load_n = r.wr_s[1] | r.s2.param_select_n;

    // Sequence control
    // Restart first, reload working set
    if (r.s2.restart) begin
      next_r.state = RSC_ST_INIT;
      next_r.work  = preload_geom;
      next_r.lat   = '0;
      next_r.walk  = '0;
      next_r.pix   = '0;
      next_r.line  = '0;
      next_r.valid = 1'b0;
      // Drop strobes still pending from the previous frame
      // Otherwise a stale store would land in the new image
      next_r.clr_pipe = '1;
      next_r.st_pipe  = '1;
    end else if (r.s2.stall_n) begin
      // Stall low simply skips the update
      unique case (r.state)
        RSC_ST_INIT: begin
          next_r.lat = r.lat + 4'h1;
          if (r.lat == 4'(RSC_START_LATENCY - 2)) begin
            next_r.state = RSC_ST_START;
          end
        end
        RSC_ST_START: begin
          next_r.state = RSC_ST_RUN;
          next_r.valid = 1'b1;
        end
        RSC_ST_RUN: begin
          advance = 1'b1;
          // Final line picks up new preload
          if (line_first_cyc) begin
            next_r.work = preload_geom;
          end
          if (frame_last) begin
            // Continue or freeze at next start
            next_r.state = r.s2.run_on ? RSC_ST_RUN : RSC_ST_HALT;
          end
        end
        RSC_ST_HALT: begin
          // Hold until run-on, resume next clock
          if (r.s2.run_on) begin
            next_r.state = RSC_ST_RUN;
          end
        end
      endcase
    end

    // Counters move only in the running state
    if (advance) begin
      next_r.walk = walk_last ? '0 : r.walk + CNT_W'(1);
      if (walk_last) begin
        next_r.pix = line_last ? '0 : r.pix + CNT_W'(1);
      end
      if (line_last) begin
        next_r.line = frame_last ? '0 : r.line + CNT_W'(1);
      end
    end


    // Strobes shift only while the sequence moves
    // Limitation: delayed strobes still queued at a halt wait for resume
    if (advance) begin
      next_r.clr_pipe = {r.clr_pipe[RSC_DELAY_MAX-1:0], ~walk_first};
      next_r.st_pipe  = {r.st_pipe[RSC_DELAY_MAX-1:0], ~walk_last};
    end

    next_r.clr_n = advance ? ~walk_first : r.clr_pipe[sum_clear_delay];
    if (sum_clear_delay != '0) begin
      next_r.clr_n = r.clr_pipe[sum_clear_delay - RSC_DELAY_W'(1)];
    end

    next_r.st_n = advance ? ~walk_last : r.st_pipe[target_store_delay];
    if (target_store_delay != '0) begin
      next_r.st_n = r.st_pipe[target_store_delay - RSC_DELAY_W'(1)];
    end

    if (r.work.nearest && r.state != RSC_ST_INIT) begin
      next_r.clr_n = 1'b0;
      next_r.st_n  = 1'b0;
    end

    // Registered drive enable, no tristate here
    // The pad ring owns the high-impedance state
    next_r.st_oe = ~r.oe_s[1];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r          <= '0;
      r.s1       <= '{1'b0, 1'b0, 1'b1, 1'b1};
      r.s2       <= '{1'b0, 1'b0, 1'b1, 1'b1};
      r.wr_s     <= 2'h3;
      r.oe_s     <= 2'h3;
      r.state    <= RSC_ST_INIT;
      r.clr_pipe <= '1;
      r.st_pipe  <= '1;
      r.load_n   <= 1'b1;
      r.clr_n    <= 1'b1;
      r.st_n     <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Every output comes straight from a flop
  assign param_load_strobe_n = r.load_n;
  assign source_valid        = r.valid;
  assign sum_clear_n         = r.clr_n;
  assign target_store_n      = r.st_n;
  assign target_store_oe     = r.st_oe;
  assign working_geom        = r.work;

endmodule // rsc_sequence

//--- src/rsc_pkg.sv
// Package for the resampling sequence control block
package rsc_pkg;

  localparam int RSC_START_LATENCY = 9;
  localparam int RSC_DELAY_MAX     = 7;
  localparam int RSC_DELAY_W       = 3;
  localparam int RSC_CNT_W         = 16;
  localparam int RSC_PARAM_W       = 32;

  // Transform geometry
  typedef struct packed {
    logic [RSC_CNT_W-1:0] walk_len;
    logic [RSC_CNT_W-1:0] line_len;
    logic [RSC_CNT_W-1:0] line_cnt;
    logic                 nearest;
  } rsc_geom_t;

  // Registered control inputs
  typedef struct packed {
    logic restart;
    logic run_on;
    logic stall_n;
    logic param_select_n;
  } rsc_ctrl_t;

  typedef enum logic [3:0] {
    RSC_ST_INIT  = 4'h1,
    RSC_ST_START = 4'h2,
    RSC_ST_RUN   = 4'h4,
    RSC_ST_HALT  = 4'h8
  } rsc_state_t;

endpackage

//--- verification/rsc_partner.sv
// Interpolator and target memory model on the strobe side
`timescale 1ns/1ps
module rsc_partner (
  // Clock
  input  wire logic clk,
  // Strobes from the block
  input  wire logic sum_clear_n,
  input  wire logic target_store_n,
  input  wire logic target_store_oe,
  // Counts seen
  output int        n_store,
  output int        n_clear
);
  logic wire_lvl, last_lvl;
  assign wire_lvl = target_store_oe ? target_store_n : 1'b1;
  initial begin
    n_store = 0;
    n_clear = 0;
    last_lvl = 1'b1;
  end
  always @(posedge clk) begin
    if (!sum_clear_n) n_clear <= n_clear + 1;
    if (!wire_lvl && last_lvl) n_store <= n_store + 1;
    last_lvl <= wire_lvl;
  end
endmodule // rsc_partner

//--- verification/rsc_sequence_chk.sv
// Port checks for the sequence control
`timescale 1ns/1ps
module rsc_sequence_chk
  import rsc_pkg::*;
(
  // Inputs watched
  input wire logic clk, arst_n, restart, run_on, stall_n,
  input wire logic param_select_n, param_write_n, target_port_enable_n,
  // Outputs watched
  input wire logic param_load_strobe_n, source_valid, sum_clear_n,
  input wire logic target_store_n, target_store_oe,
  input wire rsc_pkg::rsc_geom_t working_geom
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Sync latency makes six steady cycles a safe window
  sequence s_run; (stall_n && run_on)[*6]; endsequence
  sequence s_multi; working_geom.walk_len > 16'h1 && !working_geom.nearest; endsequence
  a_start_nine: assert property ($fell(restart) && stall_n
    |-> (!source_valid)[*8] ##[1:6] source_valid) else $error("start latency off");
  a_restart_clear: assert property (restart[*5] |-> !source_valid)
    else $error("restart left valid");
  a_param_block: assert property (param_select_n[*5] |-> param_load_strobe_n)
    else $error("blocked write passed");
  a_param_open: assert property (!param_select_n[*6] ##0 $fell(param_write_n)
    |-> ##[1:5] !param_load_strobe_n) else $error("write lost");
  a_oe_drive: assert property (!target_port_enable_n[*5] |-> target_store_oe)
    else $error("store not driven");
  a_oe_off: assert property (target_port_enable_n[*5] |-> !target_store_oe)
    else $error("store driven");
  a_clear_one: assert property (s_run ##0 s_multi ##0 $fell(sum_clear_n)
    |=> sum_clear_n) else $error("clear too long");
  a_store_one: assert property (s_run ##0 s_multi ##0 $fell(target_store_n)
    |=> target_store_n) else $error("store too long");
  a_nearest_low: assert property ((working_geom.nearest && source_valid)[*8]
    |-> !sum_clear_n && !target_store_n) else $error("nearest strobe");
  a_stall_hold: assert property ((!stall_n && !restart)[*8] |->
    $stable({sum_clear_n, target_store_n, working_geom})) else $error("moved");
endmodule // rsc_sequence_chk
bind rsc_sequence rsc_sequence_chk u_chk (.clk, .arst_n, .restart, .run_on, .stall_n,
  .param_select_n, .param_write_n, .target_port_enable_n, .param_load_strobe_n,
  .source_valid, .sum_clear_n, .target_store_n, .target_store_oe, .working_geom);

//--- verification/rsc_sequence_test.sv
// Self-checking bench for the sequence control
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR %0t %h %h", $time, (a), (b)); end end
module rsc_sequence_test;
  import rsc_pkg::*;
  // Stores still queued in the delay line at the halt are held back until resume
  typedef struct packed {rsc_geom_t g; logic [2:0] dc, ds; logic [7:0] ns;} rsc_row_t;
  logic clk = 0, arst_n = 0, restart = 1, run_on = 0, stall_n = 1, seen;
  logic param_select_n = 0, param_write_n = 1, target_port_enable_n = 0;
  logic [RSC_DELAY_W-1:0] sum_clear_delay = '0, target_store_delay = '0;
  rsc_geom_t preload_geom = '0, working_geom;
  logic param_load_strobe_n, source_valid, sum_clear_n, target_store_n, target_store_oe;
  int n_errors = 0, n_compared = 0, n_store, n_clear, base;
  rsc_row_t rows [3] = '{'{'{16'h2, 16'h1, 16'h1, 1'b0}, 3'h0, 3'h0, 8'h1},
    '{'{16'h3, 16'h2, 16'h2, 1'b0}, 3'h7, 3'h7, 8'h2},
    '{'{16'h4, 16'h3, 16'h1, 1'b0}, 3'h3, 3'h5, 8'h2}};
  rsc_sequence dut (.clk, .arst_n, .restart, .run_on, .stall_n, .param_select_n,
    .param_write_n, .preload_geom, .sum_clear_delay, .target_store_delay,
    .target_port_enable_n, .param_load_strobe_n, .source_valid, .sum_clear_n,
    .target_store_n, .target_store_oe, .working_geom);
  rsc_partner u_far (.clk, .sum_clear_n, .target_store_n, .target_store_oe, .n_store, .n_clear);
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic start(input rsc_row_t r);
    preload_geom = r.g;
    sum_clear_delay = r.dc;
    target_store_delay = r.ds;
    restart = 1;
    cyc(5);
    restart = 0;
    for (int i = 0; i < 40 && source_valid !== 1'b1; i++) cyc(1);
    base = n_store;
  endtask
  task automatic pulse_w;
    seen = 1;
    param_write_n = 0;
    cyc(1);
    param_write_n = 1;
    repeat (6) begin
      cyc(1);
      seen &= param_load_strobe_n;
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    report_and_stop;
  end
  initial begin
    cyc(2);
    arst_n = 1;
    cyc(1);
    `CHK(source_valid, 1'b0)
    foreach (rows[i]) begin
      start(rows[i]);
      `CHK(source_valid, 1'b1)
      cyc(rows[i].g.walk_len * rows[i].g.line_len * rows[i].g.line_cnt + 40);
      `CHK(n_store - base, int'(rows[i].ns))
    end
    base = n_store;
    cyc(20);
    `CHK(n_store, base)
    run_on = 1;
    cyc(20);
    `CHK(n_store > base, 1'b1)
    // New set loaded before final line
    preload_geom = rows[1].g;
    cyc(100);
    `CHK(working_geom, rows[1].g)
    stall_n = 0;
    cyc(4);
    base = n_store;
    pulse_w;
    `CHK(seen, 1'b0)
    cyc(20);
    `CHK(n_store, base)
    stall_n = 1;
    param_select_n = 1;
    cyc(4);
    pulse_w;
    `CHK(seen, 1'b1)
    param_select_n = 0;
    target_port_enable_n = 1;
    cyc(5);
    `CHK(target_store_oe, 1'b0)
    target_port_enable_n = 0;
    preload_geom = rows[2].g;
    restart = 1;
    stall_n = 0;
    cyc(6);
    `CHK(source_valid, 1'b0)
    `CHK(working_geom, rows[2].g)
    stall_n = 1;
    start('{'{16'h4, 16'h2, 16'h1, 1'b1}, 3'h0, 3'h0, 8'h0});
    cyc(12);
    `CHK({sum_clear_n, target_store_n}, 2'h0)
    report_and_stop;
  end
endmodule // rsc_sequence_test
